// >>> verilog/ddrcal_consts.svh
// constants for the dll calibration handshake block
// assumes inclusion by bare name from the package and main module
`ifndef DDRCAL_CONSTS_SVH
`define DDRCAL_CONSTS_SVH
`define DDRCAL_LANES 8
`define DDRCAL_LANE_BITS 8
`define DDRCAL_DATA_BITS 64
`endif

// >>> verilog/ddrcal_pkg.sv
// types for the dll calibration handshake block
// assumes ddrcal_consts.svh is on the include path
`include "ddrcal_consts.svh"
package ddrcal_pkg;
   typedef enum logic [1:0]
   {
      CAL_IDLE = 2'b00,
      CAL_WAIT_RISE = 2'b01,
      CAL_WAIT_FALL = 2'b10
   } ddrcal_state_e;

   // request sources seen in one cycle
   typedef struct packed
   {
      logic refresh;
      logic sr_exit;
      logic sw;
   } ddrcal_trig_s;

   typedef struct packed
   {
      ddrcal_state_e state;
      logic en_prev;
      logic pend;
      logic req;
      logic hold;
      logic done;
      logic sw_run;
   } ddrcal_ctl_s;

   typedef struct packed
   {
      logic [`DDRCAL_DATA_BITS-1:0] data;
   } ddrcal_cap_s;
endpackage : ddrcal_pkg

// >>> verilog/ddrcal_lane.sv
// one byte lane of read capture, clocked by its own read strobe
// assumes the strobe arrives already delayed by the external dll
`timescale 1ns/100ps
module ddrcal_lane
(
   input wire logic read_strobe_in,
   input wire logic reset_n,
   input wire logic [7:0] read_data_in,
   output logic [7:0] lane_data
);
   import ddrcal_pkg::*;

   // capture this lane on its own strobe edge
   always_ff @(posedge read_strobe_in or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lane_data <= 8'h00;
      end
      else
      begin
         lane_data <= read_data_in;
      end
   end
endmodule : ddrcal_lane

// >>> verilog/ddrcal_top.sv
// dll calibration handshake and per-lane read strobe capture
// assumes all control inputs synchronous to clk; strobes from delay block
//
// Overview of operation
// - each byte lane of read data is captured with its own strobe
// - no calibration request while calibration enable is low
// - request on refresh, self-refresh exit, and when enable rises
// - request also when software trigger bit is set
// - on acknowledge fall drop request and let memory accesses resume
// - during calibration only refresh may be issued to memory
// - software calibration sets done status once acknowledge drops
`timescale 1ns/100ps
`include "ddrcal_consts.svh"
module ddrcal_top
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cal_enable_bit,
   input wire logic sw_cal_trigger,
   input wire ddrcal_pkg::ddrcal_trig_s trig,
   input wire logic dll_cal_ack,
   input wire logic [`DDRCAL_LANES-1:0] read_strobe_in,
   input wire logic [`DDRCAL_DATA_BITS-1:0] read_data_in,
   output logic dll_cal_request,
   output logic access_hold,
   output logic cal_done_status,
   output ddrcal_pkg::ddrcal_cap_s read_capture
);
   import ddrcal_pkg::*;

   ddrcal_ctl_s st_r;
   ddrcal_ctl_s st_nxt;
   logic start;
   logic [`DDRCAL_DATA_BITS-1:0] cap_w;

   // any source of a new calibration, gated by enable
   assign start = cal_enable_bit & (st_r.pend | trig.refresh | trig.sr_exit
                  | (cal_enable_bit & ~st_r.en_prev) | (sw_cal_trigger & ~st_r.done));

   // handshake sequencing
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.en_prev = cal_enable_bit;
      // done clears once software drops its trigger
      if (!sw_cal_trigger)
      begin
         st_nxt.done = 1'b0;
      end
      case (st_r.state)
         CAL_IDLE:
         begin
            st_nxt.pend = 1'b0;
            if (start)
            begin
               st_nxt.state = CAL_WAIT_RISE;
               st_nxt.req = 1'b1;
               st_nxt.hold = 1'b1;
               st_nxt.sw_run = sw_cal_trigger & ~st_r.done;
            end
         end
         CAL_WAIT_RISE:
         begin
            if (dll_cal_ack)
            begin
               st_nxt.state = CAL_WAIT_FALL;
            end
         end
         CAL_WAIT_FALL:
         begin
            if (trig.refresh | trig.sr_exit)
            begin
               st_nxt.pend = 1'b1; // refresh or self-refresh exit while waiting for ack fall kept for later
            end
            if (!dll_cal_ack)
            begin
               st_nxt.state = CAL_IDLE;
               st_nxt.req = 1'b0;
               st_nxt.hold = 1'b0;
               // a refresh calibration leaves an earlier done standing
               st_nxt.done = st_nxt.done | (st_r.sw_run & sw_cal_trigger);
               st_nxt.sw_run = 1'b0;
            end
         end
         default:
         begin
            st_nxt.state = CAL_IDLE;
            st_nxt.req = 1'b0;
            st_nxt.hold = 1'b0;
         end
      endcase
      // disabling calibration withdraws any request at once
      if (!cal_enable_bit)
      begin
         st_nxt.state = CAL_IDLE;
         st_nxt.req = 1'b0;
         st_nxt.hold = 1'b0;
         st_nxt.pend = 1'b0;
         st_nxt.sw_run = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r <= '{state: CAL_IDLE, en_prev: 1'b0, pend: 1'b0, req: 1'b0,
                   hold: 1'b0, done: 1'b0, sw_run: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dll_cal_request = st_r.req;
   assign access_hold = st_r.hold;
   assign cal_done_status = st_r.done;

   // one capture lane per strobe
   genvar g;
   generate
      for (g = 0; g < `DDRCAL_LANES; g++)
      begin : g_lane
         ddrcal_lane u_lane
         (
            .read_strobe_in(read_strobe_in[g]),
            .reset_n(reset_n),
            .read_data_in(read_data_in[g*`DDRCAL_LANE_BITS +: `DDRCAL_LANE_BITS]),
            .lane_data(cap_w[g*`DDRCAL_LANE_BITS +: `DDRCAL_LANE_BITS])
         );
      end
   endgenerate
   assign read_capture.data = cap_w;


   // request only follows a cycle with enable high
   a_req_needs_en: assert property (@(posedge clk) disable iff (!reset_n)
      dll_cal_request |-> $past(cal_enable_bit))
      else $error("request while calibration disabled");

   // request gone the cycle after enable is low
   a_req_drop_dis: assert property (@(posedge clk) disable iff (!reset_n)
      !cal_enable_bit |=> !dll_cal_request)
      else $error("request still up after disable");

   // refresh from idle raises request
   a_req_on_refresh: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && trig.refresh && st_r.state == CAL_IDLE) |=> dll_cal_request)
      else $error("refresh did not raise request");

   // self-refresh exit from idle raises request
   a_req_on_srexit: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && trig.sr_exit && st_r.state == CAL_IDLE) |=> dll_cal_request)
      else $error("self-refresh exit did not raise request");

   // enable rise from idle raises request
   a_enable_rise_req: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && !st_r.en_prev && st_r.state == CAL_IDLE) |=> dll_cal_request)
      else $error("enable rise did not raise request");

   // event during the wait for ack fall is remembered
   a_pend_kept: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && st_r.state == CAL_WAIT_FALL && (trig.refresh || trig.sr_exit))
      |=> st_r.pend)
      else $error("event during calibration was lost");

   // remembered event restarts calibration from idle
   a_pend_restart: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && st_r.pend && st_r.state == CAL_IDLE) |=> dll_cal_request)
      else $error("remembered event did not restart calibration");

   // software trigger from idle raises request
   a_req_on_sw: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && sw_cal_trigger && !cal_done_status && st_r.state == CAL_IDLE)
      |=> dll_cal_request)
      else $error("software trigger did not raise request");

   // ack fall in the last wait releases request and hold
   a_req_drop_fall: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && st_r.state == CAL_WAIT_FALL && !dll_cal_ack)
      |=> (!dll_cal_request && !access_hold))
      else $error("request not dropped after ack fall");

   // hold follows the handshake state, not the request logic
   a_hold_with_req: assert property (@(posedge clk) disable iff (!reset_n)
      access_hold == (st_r.state != CAL_IDLE))
      else $error("access hold not tied to calibration");

   // done only after a software calibration with request up
   a_done_after_sw: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(cal_done_status) |-> $past(st_r.sw_run) && $past(dll_cal_request))
      else $error("done rose without software calibration");

   // done set when a software calibration completes
   a_sw_done_set: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_enable_bit && st_r.state == CAL_WAIT_FALL && !dll_cal_ack && st_r.sw_run
      && sw_cal_trigger) |=> cal_done_status)
      else $error("done not set after software calibration");

   // done stands while software keeps its trigger
   a_done_holds: assert property (@(posedge clk) disable iff (!reset_n)
      (cal_done_status && sw_cal_trigger) |=> cal_done_status)
      else $error("done dropped while trigger still set");

   // done clears once software drops its trigger
   a_done_clears: assert property (@(posedge clk) disable iff (!reset_n)
      !sw_cal_trigger |=> !cal_done_status)
      else $error("done still set after trigger cleared");

   // request held while waiting for ack rise
   a_keep_req_rise: assert property (@(posedge clk) disable iff (!reset_n)
      (dll_cal_request && !dll_cal_ack && st_r.state == CAL_WAIT_RISE && cal_enable_bit)
      |=> dll_cal_request)
      else $error("request dropped before ack seen");

   // request held while ack stands high
   a_hold_until_fall: assert property (@(posedge clk) disable iff (!reset_n)
      (dll_cal_request && dll_cal_ack && cal_enable_bit) |=> dll_cal_request)
      else $error("request dropped while ack high");

   // request up whenever a handshake is open
   a_req_in_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (st_r.state != CAL_IDLE) |-> dll_cal_request)
      else $error("handshake open without request");

   // request falls only after ack seen low or enable cleared
   a_req_fall_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(dll_cal_request) |-> (!$past(dll_cal_ack) || !$past(cal_enable_bit)))
      else $error("request fell with ack still high");
endmodule : ddrcal_top

// >>> dv/ddrcal_dll_model.sv
// behavioural delay block answering the calibration handshake
// assumes request is registered on clk by the controller
`timescale 1ns/100ps
module ddrcal_dll_model
#(
   parameter int CAL_LEN = 4
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dll_cal_request,
   output logic dll_cal_ack
);
   int wait_r;
   // ack up on request, down after calibration, then await release
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dll_cal_ack <= 1'b0;
         wait_r <= 0;
      end
      else if (wait_r == 0 && dll_cal_request)
      begin
         dll_cal_ack <= 1'b1;
         wait_r <= CAL_LEN;
      end
      else if (wait_r > 1)
         wait_r <= wait_r - 1;
      else if (wait_r == 1)
      begin
         dll_cal_ack <= 1'b0;
         wait_r <= -1;
      end
      else if (wait_r == -1 && !dll_cal_request)
         wait_r <= 0;
   end
endmodule : ddrcal_dll_model

// >>> dv/ddrcal_top_tb_top.sv
// scenario bench for the calibration handshake block
// assumes ddrcal_pkg and the dll model are compiled first
`timescale 1ns/100ps
module ddrcal_top_tb_top;
   import ddrcal_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cal_enable_bit = 1'b0;
   logic sw_cal_trigger = 1'b0;
   ddrcal_trig_s trig = '0;
   logic dll_cal_ack, dll_cal_request, access_hold, cal_done_status;
   logic [7:0] read_strobe_in = '0;
   logic [63:0] read_data_in = '0;
   logic [63:0] exp_cap = '0;
   ddrcal_cap_s read_capture;
   int n_mismatch = 0;
   int n_checks = 0;
   // 100 ns clock
   always #50 clk = ~clk;
   ddrcal_top ddrcal_top_inst (.clk(clk), .reset_n(reset_n), .cal_enable_bit(cal_enable_bit),
      .sw_cal_trigger(sw_cal_trigger), .trig(trig), .dll_cal_ack(dll_cal_ack),
      .read_strobe_in(read_strobe_in), .read_data_in(read_data_in),
      .dll_cal_request(dll_cal_request), .access_hold(access_hold),
      .cal_done_status(cal_done_status), .read_capture(read_capture));
   ddrcal_dll_model ddrcal_dll_model_inst (.clk(clk), .reset_n(reset_n),
      .dll_cal_request(dll_cal_request), .dll_cal_ack(dll_cal_ack));
   task automatic end_sim;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait on request or ack reaching a level
   task automatic wt(input bit on_ack, input logic v);
      for (int i = 0; i < 40; i++)
      begin
         @(negedge clk);
         if ((on_ack ? dll_cal_ack : dll_cal_request) === v)
            return;
      end
      n_mismatch++;
      end_sim();
   endtask : wt
   // one handshake from request to release
   task automatic run_cal;
      wt(1'b0, 1'b1);
      chk(access_hold, 1'b1);
      wt(1'b1, 1'b1);
      wt(1'b1, 1'b0);
      chk(dll_cal_request, 1'b1);
      @(negedge clk);
      chk({access_hold, dll_cal_request}, 2'b00);
   endtask : run_cal
   task automatic t_off;
      @(posedge clk);
      sw_cal_trigger <= 1'b1;
      repeat (6) @(negedge clk);
      chk(dll_cal_request, 1'b0);
      @(posedge clk);
      sw_cal_trigger <= 1'b0;
      @(posedge clk);
      cal_enable_bit <= 1'b1;
      run_cal();
   endtask : t_off
   task automatic t_kinds;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         trig <= (k == 0) ? ddrcal_trig_s'(3'h4) : ddrcal_trig_s'(3'h2);
         @(posedge clk);
         trig <= '0;
         run_cal();
         chk(cal_done_status, 1'b0);
      end
   endtask : t_kinds
   // refresh during calibration starts a second one after release
   task automatic t_pend;
      @(posedge clk);
      trig <= ddrcal_trig_s'(3'h4);
      @(posedge clk);
      trig <= '0;
      wt(1'b1, 1'b1);
      @(posedge clk);
      trig <= ddrcal_trig_s'(3'h4);
      @(posedge clk);
      trig <= '0;
      wt(1'b1, 1'b0);
      @(negedge clk);
      chk({access_hold, dll_cal_request}, 2'b00);
      run_cal();
   endtask : t_pend
   // disable in mid calibration withdraws the request
   task automatic t_dis;
      @(posedge clk);
      trig <= ddrcal_trig_s'(3'h2);
      @(posedge clk);
      trig <= '0;
      wt(1'b1, 1'b1);
      @(posedge clk);
      cal_enable_bit <= 1'b0;
      repeat (2) @(negedge clk);
      chk({access_hold, dll_cal_request}, 2'b00);
      wt(1'b1, 1'b0);
      @(posedge clk);
      cal_enable_bit <= 1'b1;
      run_cal();
   endtask : t_dis
   task automatic t_sw;
      @(posedge clk);
      sw_cal_trigger <= 1'b1;
      run_cal();
      repeat (3) @(negedge clk);
      chk({cal_done_status, dll_cal_request}, 2'b10);
      @(posedge clk);
      sw_cal_trigger <= 1'b0;
      repeat (2) @(negedge clk);
      chk({cal_done_status, dll_cal_request}, 2'b00);
   endtask : t_sw
   task automatic t_lanes;
      for (int g = 0; g < 8; g++)
      begin
         @(posedge clk);
         read_data_in <= {8{8'(8'h11 * (g + 1))}};
         exp_cap[8 * g +: 8] = 8'(8'h11 * (g + 1));
         @(posedge clk);
         read_strobe_in[g] <= 1'b1;
         @(posedge clk);
         read_strobe_in[g] <= 1'b0;
         read_data_in <= ~read_data_in;
         @(negedge clk);
         chk(read_capture.data, exp_cap);
      end
   endtask : t_lanes
   // reset, then scenarios in turn
   initial
   begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_off();
      t_kinds();
      t_pend();
      t_dis();
      t_sw();
      t_lanes();
      end_sim();
   end
endmodule : ddrcal_top_tb_top
